// ---- rtpc_pkg.sv ----
// package: register map, field layout and type definitions of the real-time periodic counter
package rtpc_pkg;
	// printed offsets are not all multiples of four, so they are indices
	localparam logic [15:0] IDX_SC1       = 16'h306a;
	localparam logic [15:0] IDX_SC2       = 16'h306b;
	localparam logic [15:0] IDX_MODH      = 16'h306c;
	localparam logic [15:0] IDX_MODL      = 16'h306d;
	localparam logic [15:0] IDX_CNTH      = 16'h306e;
	localparam logic [15:0] IDX_CNTL      = 16'h306f;
	localparam logic [15:0] IDX_IRQ_STAT  = 16'h3070;
	localparam logic [15:0] IDX_IRQ_EN    = 16'h3071;
	localparam logic [15:0] IDX_IRQ_CLR   = 16'h3072;
	localparam int          ADDR_W        = 18;
	// field positions
	localparam int          FLAG_BIT      = 7;
	localparam int          IE_BIT        = 6;
	localparam int          SRC_HI        = 7;
	localparam int          SRC_LO        = 6;
	localparam int          DIV_HI        = 2;
	localparam int          DIV_LO        = 0;
	// reset values
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [15:0] RST_WORD      = 16'h0000;
	// source codes
	localparam logic [1:0]  SRC_CRYSTAL   = 2'b00;
	localparam logic [1:0]  SRC_LOW_POWER = 2'b01;
	localparam logic [2:0]  DIV_OFF       = 3'b000;
	// decimal divide values for the low-power style codes 110 and 111
	localparam logic [15:0] DIV_DEC_A     = 16'd100;
	localparam logic [15:0] DIV_DEC_B     = 16'd1000;
	localparam logic [15:0] DIV_BIN_BASE  = 16'd128;
	// axi responses
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;

	// one snapshot of the control fields
	typedef struct packed {
		logic [1:0] source;
		logic [2:0] divider;
	} rtpc_cfg_type;
endpackage

// ---- rtpc_top.sv ----
// real-time periodic counter with axi4-lite register slave
module rtpc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        crystal_oscillator,
	input  wire logic        low_power_oscillator,
	input  wire logic [17:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [17:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	// synchronisers for the two oscillator pins
	logic [1:0] xo_sync_q;
	logic [1:0] lp_sync_q;
	logic       xo_last_q;
	logic       lp_last_q;

	// register state
	logic                  flag_q, flag_d;
	logic                  ie_q, ie_d;
	rtpc_pkg::rtpc_cfg_type cfg_q, cfg_d;
	logic [15:0]           mod_q, mod_d;
	logic [15:0]           cnt_q, cnt_d;
	logic [15:0]           pre_q, pre_d;
	logic                  sts_q, sts_d;
	logic                  sts_en_q, sts_en_d;

	// bus state
	logic [17:0] aw_q, aw_d;
	logic        awh_q, awh_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        wh_q, wh_d;
	logic        bv_q, bv_d;
	logic [1:0]  br_q, br_d;
	logic        rv_q, rv_d;
	logic [31:0] rd_q, rd_d;
	logic [1:0]  rr_q, rr_d;

	logic        src_tick;
	logic        pre_tick;
	logic [15:0] div_last;
	logic        match;
	logic        wr_go;
	logic [15:0] wr_idx;
	logic [15:0] rd_idx;
	logic        wr_ok;
	logic [7:0]  wbyte;

	// two flops per pin, then a third flop for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xo_sync_q <= 2'b00;
			lp_sync_q <= 2'b00;
			xo_last_q <= 1'b0;
			lp_last_q <= 1'b0;
		end else begin
			xo_sync_q <= {xo_sync_q[0], crystal_oscillator};
			lp_sync_q <= {lp_sync_q[0], low_power_oscillator};
			xo_last_q <= xo_sync_q[1];
			lp_last_q <= lp_sync_q[1];
		end
	end

	// source select: rising edge of chosen oscillator, or every bus clock
	always_comb begin
		unique case (cfg_q.source)
			rtpc_pkg::SRC_CRYSTAL:   src_tick = xo_sync_q[1] & ~xo_last_q;
			rtpc_pkg::SRC_LOW_POWER: src_tick = lp_sync_q[1] & ~lp_last_q;
			default:                 src_tick = 1'b1;
		endcase
	end

	// terminal count of the prescaler for the selected ratio
	always_comb begin
		div_last = rtpc_pkg::RST_WORD;
		if (!cfg_q.source[0]) begin
			div_last = 16'((16'd1 << (cfg_q.divider - 3'd1)) - 16'd1);
		end else if (cfg_q.divider == 3'b110) begin
			div_last = 16'(rtpc_pkg::DIV_DEC_A - 16'd1);
		end else if (cfg_q.divider == 3'b111) begin
			div_last = 16'(rtpc_pkg::DIV_DEC_B - 16'd1);
		end else begin
			div_last = 16'((rtpc_pkg::DIV_BIN_BASE << (cfg_q.divider - 3'd1)) - 16'd1);
		end
	end

	assign pre_tick = (cfg_q.divider != rtpc_pkg::DIV_OFF) && src_tick && (pre_q == div_last);
	assign match    = pre_tick && (cnt_q == mod_q);

	// write path decode
	assign wr_go  = awh_q && wh_q && !bv_q;
	assign wr_idx = 16'(aw_q >> 2);
	assign rd_idx = 16'(s_axi_araddr >> 2);
	assign wbyte  = wd_q[7:0];
	assign wr_ok  = wstrb_q[0]; // every register sits in byte lane 0

	// counter, register file and interrupt status next state
	always_comb begin
		flag_d   = flag_q;
		ie_d     = ie_q;
		cfg_d    = cfg_q;
		mod_d    = mod_q;
		sts_en_d = sts_en_q;
		sts_d    = sts_q;
		pre_d    = pre_q;
		cnt_d    = cnt_q;
		// prescaler and counter keep running unless the divider is off
		if (cfg_q.divider != rtpc_pkg::DIV_OFF && src_tick) begin
			pre_d = (pre_q == div_last) ? rtpc_pkg::RST_WORD : 16'(pre_q + 16'd1);
		end
		if (pre_tick) begin
			cnt_d = match ? rtpc_pkg::RST_WORD : 16'(cnt_q + 16'd1);
		end
		if (wr_go && wr_ok) begin
			unique case (wr_idx)
				rtpc_pkg::IDX_SC1: begin
					if (wbyte[rtpc_pkg::FLAG_BIT]) begin
						flag_d = 1'b0;
					end
					ie_d = wbyte[rtpc_pkg::IE_BIT];
				end
				rtpc_pkg::IDX_SC2: begin
					cfg_d.source  = wbyte[rtpc_pkg::SRC_HI:rtpc_pkg::SRC_LO];
					cfg_d.divider = wbyte[rtpc_pkg::DIV_HI:rtpc_pkg::DIV_LO];
					if (cfg_d != cfg_q) begin
						pre_d = rtpc_pkg::RST_WORD;
						cnt_d = rtpc_pkg::RST_WORD;
					end
				end
				rtpc_pkg::IDX_MODH:    mod_d[15:8] = wbyte;
				rtpc_pkg::IDX_MODL:    mod_d[7:0]  = wbyte;
				rtpc_pkg::IDX_IRQ_EN:  sts_en_d    = wbyte[0];
				rtpc_pkg::IDX_IRQ_CLR: begin
					if (wbyte[0]) begin
						sts_d = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// hardware set wins over a same-cycle clear
		if (match) begin
			flag_d = 1'b1;
			sts_d  = 1'b1;
		end
	end

	// core state registers, all cleared by reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q   <= 1'b0;
			ie_q     <= 1'b0;
			cfg_q    <= '0;
			mod_q    <= rtpc_pkg::RST_WORD;
			cnt_q    <= rtpc_pkg::RST_WORD;
			pre_q    <= rtpc_pkg::RST_WORD;
			sts_q    <= 1'b0;
			sts_en_q <= 1'b0;
		end else begin
			flag_q   <= flag_d;
			ie_q     <= ie_d;
			cfg_q    <= cfg_d;
			mod_q    <= mod_d;
			cnt_q    <= cnt_d;
			pre_q    <= pre_d;
			sts_q    <= sts_d;
			sts_en_q <= sts_en_d;
		end
	end

	// interrupt: documented enable, or the extra status/enable pair
	assign irq = (flag_q && ie_q) || (sts_q && sts_en_q);

	// axi4-lite handshakes and answers
	always_comb begin
		aw_d    = aw_q;
		awh_d   = awh_q;
		wd_d    = wd_q;
		wstrb_d = wstrb_q;
		wh_d    = wh_q;
		bv_d    = bv_q;
		br_d    = br_q;
		rv_d    = rv_q;
		rd_d    = rd_q;
		rr_d    = rr_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d  = s_axi_awaddr;
			awh_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd_d    = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
			wh_d    = 1'b1;
		end
		if (wr_go) begin
			awh_d = 1'b0;
			wh_d  = 1'b0;
			bv_d  = 1'b1;
			// a write with lane 0 off to a mapped index is ignored but still answered okay
			br_d  = (wr_idx >= rtpc_pkg::IDX_SC1 && wr_idx <= rtpc_pkg::IDX_IRQ_CLR)
				? rtpc_pkg::RESP_OKAY : rtpc_pkg::RESP_SLVERR;
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rv_d = 1'b1;
			rr_d = rtpc_pkg::RESP_OKAY;
			unique case (rd_idx)
				rtpc_pkg::IDX_SC1:      rd_d = {24'h00_0000, flag_q, ie_q, 6'h00};
				rtpc_pkg::IDX_SC2:      rd_d = {24'h00_0000, cfg_q.source, 3'b000, cfg_q.divider};
				rtpc_pkg::IDX_MODH:     rd_d = {24'h00_0000, mod_q[15:8]};
				rtpc_pkg::IDX_MODL:     rd_d = {24'h00_0000, mod_q[7:0]};
				rtpc_pkg::IDX_CNTH:     rd_d = {24'h00_0000, cnt_q[15:8]};
				rtpc_pkg::IDX_CNTL:     rd_d = {24'h00_0000, cnt_q[7:0]};
				rtpc_pkg::IDX_IRQ_STAT: rd_d = {31'h0000_0000, sts_q};
				rtpc_pkg::IDX_IRQ_EN:   rd_d = {31'h0000_0000, sts_en_q};
				rtpc_pkg::IDX_IRQ_CLR:  rd_d = 32'h0000_0000;
				default: begin
					rd_d = 32'h0000_0000;
					rr_d = rtpc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
	end

	// bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q    <= '0;
			awh_q   <= 1'b0;
			wd_q    <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			wh_q    <= 1'b0;
			bv_q    <= 1'b0;
			br_q    <= rtpc_pkg::RESP_OKAY;
			rv_q    <= 1'b0;
			rd_q    <= 32'h0000_0000;
			rr_q    <= rtpc_pkg::RESP_OKAY;
		end else begin
			aw_q    <= aw_d;
			awh_q   <= awh_d;
			wd_q    <= wd_d;
			wstrb_q <= wstrb_d;
			wh_q    <= wh_d;
			bv_q    <= bv_d;
			br_q    <= br_d;
			rv_q    <= rv_d;
			rd_q    <= rd_d;
			rr_q    <= rr_d;
		end
	end

	assign s_axi_awready = !awh_q && !bv_q;
	assign s_axi_wready  = !wh_q && !bv_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = !rv_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;

	// counter returns to zero one cycle after a match
	match_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		match |=> cnt_q == 16'h0000 && flag_q)
		else $error("counter not cleared on match");
	// flag kept when a match meets a clear
	set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(match && wr_go && wr_idx == rtpc_pkg::IDX_SC1) |=> flag_q)
		else $error("match lost");
	// clear by writing one
	flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_go && wstrb_q[0] && wr_idx == rtpc_pkg::IDX_SC1 && wd_q[7] && !match) |=> !flag_q)
		else $error("flag not cleared");
	// write of zero leaves the flag
	flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(flag_q && !(wr_go && wr_idx == rtpc_pkg::IDX_SC1 && wd_q[7])) |=> flag_q)
		else $error("flag dropped");

	// an enabled match raises the interrupt on the next cycle
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(match && ie_q && !wr_go) |=> irq)
		else $error("interrupt missing");
	// flag only set by a match
	flag_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(flag_q) |-> $past(match))
		else $error("flag set without match");
	// divider off freezes the counter
	div_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_q.divider == rtpc_pkg::DIV_OFF && !wr_go) |=> $stable(cnt_q))
		else $error("counter moved");
	// each prescaler tick without a match adds one to the count
	count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pre_tick && !match && !wr_go) |=> cnt_q == $past(cnt_q) + 16'd1)
		else $error("bad count");

	// reset leaves the register state at zero
	reset_clear_a: assert property (@(posedge aclk)
		!aresetn |=> !flag_q && !ie_q && cfg_q == '0 && mod_q == 16'h0000 && cnt_q == 16'h0000)
		else $error("register not cleared by reset");
	// count bytes ignore writes
	count_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_go && (wr_idx == rtpc_pkg::IDX_CNTH || wr_idx == rtpc_pkg::IDX_CNTL) && !pre_tick) |=> $stable(cnt_q))
		else $error("count byte written");
	// a new source or divider clears prescaler and counter
	cfg_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_go && wr_ok && wr_idx == rtpc_pkg::IDX_SC2
			&& {wbyte[rtpc_pkg::SRC_HI:rtpc_pkg::SRC_LO], wbyte[rtpc_pkg::DIV_HI:rtpc_pkg::DIV_LO]} != cfg_q)
		|=> cnt_q == 16'h0000 && pre_q == 16'h0000)
		else $error("selection change kept the count");
	// bus clock codes tick the prescaler every cycle
	src_bus_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_q.source[1] |-> src_tick)
		else $error("bus clock source idle");

	// prescaler never passes its terminal count
	pre_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_q.divider != rtpc_pkg::DIV_OFF) |-> pre_q <= div_last)
		else $error("prescaler overran");
	// reads of the first control register show zero in the reserved bits
	reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx == rtpc_pkg::IDX_SC1) |=> s_axi_rdata[5:0] == 6'h00)
		else $error("reserved bits set");
	// interrupt enable follows the written bit
	ie_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_go && wr_ok && wr_idx == rtpc_pkg::IDX_SC1) |=> ie_q == wd_q[rtpc_pkg::IE_BIT])
		else $error("enable not written");
	// sticky status set by each match
	sts_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		match |=> sts_q)
		else $error("status not set");

	// sticky status held until a clear without a match
	sts_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sts_q && !(wr_go && wr_ok && wr_idx == rtpc_pkg::IDX_IRQ_CLR && wd_q[0])) |=> sts_q)
		else $error("status dropped");
	// write answer stands until taken
	bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer withdrawn");
	// read answer stands until taken
	rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer withdrawn");
endmodule

// ---- tb_rtpc_top.sv ----
// self-checking testbench of the real-time periodic counter
module tb_rtpc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk                 = 1'b0;
	logic        aresetn              = 1'b0;
	logic        crystal_oscillator   = 1'b0;
	logic        low_power_oscillator = 1'b0;
	logic [17:0] s_axi_awaddr         = 18'h0_0000;
	logic [17:0] s_axi_araddr         = 18'h0_0000;
	logic [31:0] s_axi_wdata          = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb          = 4'h0;
	logic        s_axi_awvalid        = 1'b0;
	logic        s_axi_wvalid         = 1'b0;
	logic        s_axi_bready         = 1'b0;
	logic        s_axi_arvalid        = 1'b0;
	logic        s_axi_rready         = 1'b0;
	logic [3:0]  strb                 = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int          bad_count            = 0;
	int          checks               = 0;
	int          cyc                  = 0;
	logic [7:0]  d;
	logic [1:0]  r;
	time         t0, t1, t2;
	// rows: control two value, modulo, expected cycles between matches
	logic [39:0] row [17] = '{40'h83_0003_0010, 40'h84_0000_0008, 40'h85_0000_0010, 40'h86_0000_0020,
		40'h87_0000_0040, 40'hc1_0000_0080, 40'hc2_0000_0100, 40'hc3_0000_0200, 40'hc4_0000_0400,
		40'hc5_0000_0800, 40'hc6_0000_0064, 40'hc7_0000_03e8, 40'h01_0000_0010, 40'h41_0000_0400,
		40'h87_0005_0180, 40'h81_0100_0101, 40'h82_0007_0010};

	rtpc_top rtpc_top_i (.aclk, .aresetn, .crystal_oscillator, .low_power_oscillator, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

	// bus clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// slow oscillators: crystal rises every 16 cycles, low-power every 8
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc % 8 == 7)
			crystal_oscillator <= ~crystal_oscillator;
		if (cyc % 4 == 3)
			low_power_oscillator <= ~low_power_oscillator;
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one register write, address and data offered together
	task automatic wr(input logic [15:0] idx, input logic [7:0] v, output logic [1:0] resp);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// one register read
	task automatic rd(input logic [15:0] idx, output logic [7:0] v, output logic [1:0] resp);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata[7:0];
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// read and compare one byte with an okay response
	task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		logic [1:0] rr;
		rd(idx, v, rr);
		chk("read data", {24'h00_0000, v}, {24'h00_0000, exp});
		chk("read resp", {30'h0000_0000, rr}, {30'h0000_0000, rtpc_pkg::RESP_OKAY});
	endtask

	// wait for the interrupt line under a bounded count
	task automatic wait_irq(output time t);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (irq !== 1'b1 && n < 5000);
		if (n >= 5000)
			chk("irq timeout", 32'h0000_0000, 32'h0000_0001);
		t = $time;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// interval between matches for each source, divider and modulo
		foreach (row[i]) begin
			wr(rtpc_pkg::IDX_MODH, row[i][31:24], r);
			wr(rtpc_pkg::IDX_MODL, row[i][23:16], r);
			wr(rtpc_pkg::IDX_SC2, row[i][39:32], r);
			rchk(rtpc_pkg::IDX_SC2, row[i][39:32]);
			wr(rtpc_pkg::IDX_SC1, 8'hc0, r);
			wait_irq(t0);
			wr(rtpc_pkg::IDX_SC1, 8'hc0, r);
			wait_irq(t1);
			wr(rtpc_pkg::IDX_SC1, 8'hc0, r);
			wait_irq(t2);
			chk("period", 32'((t2 - t1) / 10), {16'h0000, row[i][15:0]});
		end
		// second reset in mid-run clears the six control, modulo and count registers
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int k = 0; k < 6; k++)
			rchk(rtpc_pkg::IDX_SC1 + 16'(k), 8'h00);
		chk("irq after reset", {31'h0000_0000, irq}, 32'h0000_0000);
		// unmapped index answers with an error and zero data
		rd(16'h3000, d, r);
		chk("unmapped resp", {30'h0000_0000, r}, {30'h0000_0000, rtpc_pkg::RESP_SLVERR});
		chk("unmapped data", {24'h00_0000, d}, 32'h0000_0000);
		// reserved bits read zero, the high modulo byte reads back, the low count byte ignores writes
		wr(rtpc_pkg::IDX_SC1, 8'h3f, r);
		rchk(rtpc_pkg::IDX_SC1, 8'h00);
		wr(rtpc_pkg::IDX_SC2, 8'h38, r);
		rchk(rtpc_pkg::IDX_SC2, 8'h00);
		wr(rtpc_pkg::IDX_MODH, 8'ha5, r);
		rchk(rtpc_pkg::IDX_MODH, 8'ha5);
		wr(rtpc_pkg::IDX_CNTL, 8'h55, r);
		rchk(rtpc_pkg::IDX_CNTL, 8'h00);
		// flag set with the interrupt masked, then enabled, then cleared
		wr(rtpc_pkg::IDX_MODH, 8'h00, r);
		wr(rtpc_pkg::IDX_MODL, 8'h03, r);
		wr(rtpc_pkg::IDX_SC2, 8'h81, r);
		repeat (20) @(posedge aclk);
		wr(rtpc_pkg::IDX_SC2, 8'h80, r);
		rchk(rtpc_pkg::IDX_CNTL, 8'h00);
		rchk(rtpc_pkg::IDX_CNTH, 8'h00);
		rchk(rtpc_pkg::IDX_SC1, 8'h80);
		chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
		wr(rtpc_pkg::IDX_SC1, 8'h40, r);
		rchk(rtpc_pkg::IDX_SC1, 8'hc0);
		chk("irq enabled", {31'h0000_0000, irq}, 32'h0000_0001);
		wr(rtpc_pkg::IDX_SC1, 8'hc0, r);
		rchk(rtpc_pkg::IDX_SC1, 8'h40);
		chk("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
		// sticky status, enable and clear of the extra interrupt registers
		rchk(rtpc_pkg::IDX_IRQ_STAT, 8'h01);
		wr(rtpc_pkg::IDX_IRQ_EN, 8'h01, r);
		chk("irq status", {31'h0000_0000, irq}, 32'h0000_0001);
		wr(rtpc_pkg::IDX_IRQ_CLR, 8'h01, r);
		rchk(rtpc_pkg::IDX_IRQ_STAT, 8'h00);
		rchk(rtpc_pkg::IDX_IRQ_CLR, 8'h00);
		chk("irq status cleared", {31'h0000_0000, irq}, 32'h0000_0000);
		// write answers: unmapped index refused, lane 0 off leaves the register alone
		wr(16'h3000, 8'h00, r);
		chk("write resp unmapped", {30'h0000_0000, r}, {30'h0000_0000, rtpc_pkg::RESP_SLVERR});
		strb = 4'he;
		wr(rtpc_pkg::IDX_MODH, 8'h5a, r);
		strb = 4'hf;
		chk("write resp lane off", {30'h0000_0000, r}, {30'h0000_0000, rtpc_pkg::RESP_OKAY});
		rchk(rtpc_pkg::IDX_MODH, 8'h00);
		// a match in every cycle meets the clear, and the flag survives
		wr(rtpc_pkg::IDX_MODL, 8'h00, r);
		wr(rtpc_pkg::IDX_SC2, 8'h81, r);
		wr(rtpc_pkg::IDX_SC1, 8'hc0, r);
		rchk(rtpc_pkg::IDX_SC1, 8'hc0);
		chk("irq held", {31'h0000_0000, irq}, 32'h0000_0001);
		wr(rtpc_pkg::IDX_SC2, 8'h80, r);
		test_done();
	end

	// watchdog against a hung handshake
	initial begin
		repeat (90000) @(posedge aclk);
		bad_count++;
		test_done();
	end
endmodule
